// ==== logic/irv_vector_map.sv ====
// Top of the interrupt and reset vector map with elevation register and scratch RAM.
// Assumes request and enable inputs come from logic on clk_sys; the reset pin is asynchronous.
//
// Summary of operation
// [RULE_01] Timer 1 accumulator overflow, enabled and unmasked, vectors to 0xFFAC.
// [RULE_02] Timer 1 accumulator edge, when enabled, vectors to 0xFFAA.
// [RULE_03] Timer 2 channels 4..7 vector to 0xFFA6..0xFFA0, overflow to 0xFF9E.
// [RULE_04] Timer 2 accumulator overflow, when enabled, vectors to 0xFF9C.
// [RULE_05] Timer 2 accumulator edge, when enabled, vectors to 0xFF9A.
// [RULE_06] PWM reloads A..C vector 0xFF98..0xFF94, faults 0..3 vector 0xFF92..0xFF8C.
// [RULE_07] Power-on, pin and low-voltage resets: priority 1, vector 0xFFFE.
// [RULE_08] Clock monitor reset priority 2 at 0xFFFC, watchdog priority 3 at 0xFFFA.
// [RULE_09] srst returns every register to its start-up value; other resets clear elevation, interrupt outputs and read data and record their cause.
// [RULE_10] RAM contents survive reset and are never cleared automatically.
// [RULE_11] Writing a source's vector low byte to elevation makes it win.
// [RULE_12] Timer 1 channels 4..7 vector 0xFFB6..0xFFB0, overflow to 0xFFAE.
// [RULE_13] Otherwise the pending source with the highest vector address wins.
// [RULE_14] Reserved vector slots are never produced.
`timescale 1ns/1ps
module irv_vector_map (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic iMask,
   input wire logic [3:0] tim1ChReq,
   input wire logic [3:0] tim1ChannelIrqEn,
   input wire logic tim1OvfReq,
   input wire logic tim1OverflowIrqEn,
   input wire logic tim1PaOvfReq,
   input wire logic tim1PulseAccumOverflowIrqEn,
   input wire logic tim1PaEdgeReq,
   input wire logic tim1PulseAccumEdgeIrqEn,
   input wire logic [3:0] tim2ChReq,
   input wire logic [3:0] tim2ChannelIrqEn,
   input wire logic tim2OvfReq,
   input wire logic tim2OverflowIrqEn,
   input wire logic tim2PaOvfReq,
   input wire logic tim2PulseAccumOverflowIrqEn,
   input wire logic tim2PaEdgeReq,
   input wire logic tim2PulseAccumEdgeIrqEn,
   input wire logic [2:0] pwmReloadReq,
   input wire logic [2:0] genReloadIrqEn,
   input wire logic [3:0] faultReq,
   input wire logic [3:0] faultIrqEn,
   input wire logic elevWrEn,
   input wire logic [7:0] elevWrData,
   input wire logic porReq,
   input wire logic extResetPinN,
   input wire logic lowVoltReq,
   input wire logic clkMonReq,
   input wire logic watchdogReq,
   input wire logic ramWrEn,
   input wire logic [irv_pkg::RAM_AW-1:0] ramAddr,
   input wire logic [7:0] ramWrData,
   output logic irqValid,
   output logic [15:0] irqVector,
   output logic [7:0] elevation,
   output logic [15:0] resetVector,
   output logic [1:0] resetPriority,
   output logic resetSeen,
   output logic [7:0] ramRdData
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   irv_pkg::irv_state_t q;
   irv_pkg::irv_state_t d;
   logic [irv_pkg::NUM_SRC-1:0] rawReq;
   logic [irv_pkg::NUM_SRC-1:0] gatedReq;
   logic [irv_pkg::NUM_SRC-1:0] elevMatch;
   logic powerRst;
   logic localRst;
   logic [7:0] ram [irv_pkg::RAM_DEPTH];

   irv_arb_if arbIf ();

   irv_arbiter u_arbiter (
      .arb (arbIf.arb)
   );

   // ----------------------------------------------------------------
   // Request gating
   // ----------------------------------------------------------------
   always_comb
   begin
      rawReq[irv_pkg::IDX_T1_CH +: 4] = tim1ChReq & tim1ChannelIrqEn; // [RULE_12]
      rawReq[irv_pkg::IDX_T1_OVF] = tim1OvfReq & tim1OverflowIrqEn; // [RULE_12]
      rawReq[irv_pkg::IDX_T1_PA_OVF] = tim1PaOvfReq & tim1PulseAccumOverflowIrqEn; // [RULE_01]
      rawReq[irv_pkg::IDX_T1_PA_EDGE] = tim1PaEdgeReq & tim1PulseAccumEdgeIrqEn; // [RULE_02]
      rawReq[irv_pkg::IDX_T2_CH +: 4] = tim2ChReq & tim2ChannelIrqEn; // [RULE_03]
      rawReq[irv_pkg::IDX_T2_OVF] = tim2OvfReq & tim2OverflowIrqEn; // [RULE_03]
      rawReq[irv_pkg::IDX_T2_PA_OVF] = tim2PaOvfReq & tim2PulseAccumOverflowIrqEn; // [RULE_04]
      rawReq[irv_pkg::IDX_T2_PA_EDGE] = tim2PaEdgeReq & tim2PulseAccumEdgeIrqEn; // [RULE_05]
      rawReq[irv_pkg::IDX_PWM_RELOAD +: 3] = pwmReloadReq & genReloadIrqEn; // [RULE_06]
      rawReq[irv_pkg::IDX_FAULT +: 4] = faultReq & faultIrqEn; // [RULE_06]
      // Every source here is maskable by the core's I bit
      gatedReq = rawReq & {irv_pkg::NUM_SRC{~iMask}}; // [RULE_01]
      for (int i = 0; i < irv_pkg::NUM_SRC; i++)
      begin
         elevMatch[i] = irv_pkg::srcVecLow(irv_pkg::SRC_IDX_W'(i)) == q.elev;
      end
   end

   assign arbIf.req = gatedReq;
   assign arbIf.elev = q.elev;

   // ----------------------------------------------------------------
   // Reset sources
   // ----------------------------------------------------------------
   // Pin is judged only after the second synchroniser stage
   assign powerRst = porReq | lowVoltReq | ~q.rstSync[1];
   assign localRst = powerRst | clkMonReq | watchdogReq;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      d = q;
      d.rstSync = {q.rstSync[0], extResetPinN};
      if (elevWrEn)
         d.elev = elevWrData;
      d.irqValid = arbIf.valid;
      // Hold a zero vector while idle so a stale slot is never presented
      d.irqVector = arbIf.valid ? {irv_pkg::VEC_PAGE, arbIf.vecLow} : 16'h0000; // [RULE_14]
      d.ramRdData = ram[ramAddr];
      if (localRst)
      begin
         d.elev = irv_pkg::ELEV_RESET; // [RULE_09]
         d.irqValid = 1'b0; // [RULE_09]
         d.irqVector = 16'h0000; // [RULE_09]
         d.ramRdData = 8'h00;
         d.resetSeen = 1'b1;
         if (powerRst)
         begin
            d.resetVector = irv_pkg::RST_VEC_POWER; // [RULE_07]
            d.resetPriority = irv_pkg::RST_PRIO_POWER; // [RULE_07]
         end
         else if (clkMonReq)
         begin
            d.resetVector = irv_pkg::RST_VEC_CLKMON; // [RULE_08]
            d.resetPriority = irv_pkg::RST_PRIO_CLKMON; // [RULE_08]
         end
         else
         begin
            d.resetVector = irv_pkg::RST_VEC_WDOG; // [RULE_08]
            d.resetPriority = irv_pkg::RST_PRIO_WDOG; // [RULE_08]
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         q <= irv_pkg::STATE_RESET; // [RULE_09]
      else
         q <= d;
   end

   // ----------------------------------------------------------------
   // Scratch RAM
   // ----------------------------------------------------------------
   // No reset branch: contents must outlive every reset; writes are refused while one is active
   always_ff @(posedge clk_sys)
   begin
      if (ramWrEn && !srst && !localRst)
         ram[ramAddr] <= ramWrData; // [RULE_10]
   end

   assign irqValid = q.irqValid;
   assign irqVector = q.irqVector;
   assign elevation = q.elev;
   assign resetVector = q.resetVector;
   assign resetPriority = q.resetPriority;
   assign resetSeen = q.resetSeen;
   assign ramRdData = q.ramRdData;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_tim1PaOvf;
      @(posedge clk_sys) disable iff (srst || localRst)
      gatedReq == (21'd1 << irv_pkg::IDX_T1_PA_OVF) |=> irqValid && irqVector == 16'hffac;
   endproperty
   a_tim1PaOvf: assert property (p_tim1PaOvf) else $error("timer1 acc overflow vector wrong"); // [RULE_01]

   property p_maskBlocks;
      @(posedge clk_sys) disable iff (srst || localRst)
      iMask |=> !irqValid;
   endproperty
   a_maskBlocks: assert property (p_maskBlocks) else $error("masked request presented"); // [RULE_01]

   property p_tim1PaEdge;
      @(posedge clk_sys) disable iff (srst || localRst)
      !iMask && tim1PaEdgeReq && tim1PulseAccumEdgeIrqEn && rawReq[5:0] == 6'h00
         && !(|(gatedReq & elevMatch & ~(21'd1 << irv_pkg::IDX_T1_PA_EDGE)))
      |=> irqVector == 16'hffaa;
   endproperty
   a_tim1PaEdge: assert property (p_tim1PaEdge) else $error("timer1 acc edge vector wrong"); // [RULE_02]

   property p_tim2Ch7;
      @(posedge clk_sys) disable iff (srst || localRst)
      gatedReq == (21'd1 << (irv_pkg::IDX_T2_CH + 3)) |=> irqVector == 16'hffa0;
   endproperty
   a_tim2Ch7: assert property (p_tim2Ch7) else $error("timer2 channel 7 vector wrong"); // [RULE_03]

   property p_tim2Acc;
      @(posedge clk_sys) disable iff (srst || localRst)
      gatedReq == (21'd1 << irv_pkg::IDX_T2_PA_OVF) ##1 gatedReq == (21'd1 << irv_pkg::IDX_T2_PA_EDGE)
      |-> irqVector == 16'hff9c ##1 irqVector == 16'hff9a;
   endproperty
   a_tim2Acc: assert property (p_tim2Acc) else $error("timer2 accumulator vectors wrong"); // [RULE_04]

   property p_fault3;
      @(posedge clk_sys) disable iff (srst || localRst)
      gatedReq == (21'd1 << (irv_pkg::IDX_FAULT + 3)) |=> irqVector == 16'hff8c;
   endproperty
   a_fault3: assert property (p_fault3) else $error("fault 3 vector wrong"); // [RULE_06]

   property p_tim1Ch4;
      @(posedge clk_sys) disable iff (srst || localRst)
      gatedReq[0] && !(|(gatedReq & elevMatch)) |=> irqVector == 16'hffb6;
   endproperty
   a_tim1Ch4: assert property (p_tim1Ch4) else $error("highest slot did not win"); // [RULE_13]

   property p_powerReset;
      @(posedge clk_sys) disable iff (srst)
      (porReq || lowVoltReq) |=> resetVector == 16'hfffe && resetPriority == 2'h1;
   endproperty
   a_powerReset: assert property (p_powerReset) else $error("power reset vector wrong"); // [RULE_07]

   property p_lowerResets;
      @(posedge clk_sys) disable iff (srst)
      !powerRst && (clkMonReq || watchdogReq)
      |=> resetVector == (($past(clkMonReq)) ? 16'hfffc : 16'hfffa)
         && resetPriority == ($past(clkMonReq) ? 2'h2 : 2'h3);
   endproperty
   a_lowerResets: assert property (p_lowerResets) else $error("clkmon or watchdog reset wrong"); // [RULE_08]

   property p_resetClears;
      @(posedge clk_sys) disable iff (srst)
      localRst |=> !irqValid && irqVector == 16'h0000 && elevation == irv_pkg::ELEV_RESET;
   endproperty
   a_resetClears: assert property (p_resetClears) else $error("reset left state behind"); // [RULE_09]

   property p_elevWins;
      @(posedge clk_sys) disable iff (srst || localRst)
      |(gatedReq & elevMatch) |=> irqVector[7:0] == $past(q.elev);
   endproperty
   a_elevWins: assert property (p_elevWins) else $error("elevated source did not win"); // [RULE_11]

   property p_noReserved;
      @(posedge clk_sys) disable iff (srst)
      irqValid |-> irqVector[15:8] == 8'hff && irv_pkg::isValidVecLow(irqVector[7:0]);
   endproperty
   a_noReserved: assert property (p_noReserved) else $error("reserved vector produced"); // [RULE_14]

   c_elevated: cover property (@(posedge clk_sys) disable iff (srst)
      $countones(gatedReq) > 1 && |(gatedReq & elevMatch & ~21'd1));
   c_watchdog: cover property (@(posedge clk_sys) disable iff (srst) watchdogReq && !powerRst);
   c_pinReset: cover property (@(posedge clk_sys) disable iff (srst) $fell(q.rstSync[1]));
   c_ramKept: cover property (@(posedge clk_sys) ramWrEn ##1 localRst ##1 !localRst);

endmodule : irv_vector_map

// ==== logic/irv_pkg.sv ====
// Constants, vector table helpers and state type for the interrupt and reset vector map.
// Assumes a single bus clock domain; request inputs come from logic on that clock.
package irv_pkg;

   // ----------------------------------------------------------------
   // Source table
   // ----------------------------------------------------------------
   localparam int NUM_SRC = 21;
   localparam int SRC_IDX_W = 5;
   localparam logic [7:0] VEC_PAGE = 8'hff;
   // Timer 1 slots run down from 0xb6, timer 2 and motor PWM from 0xa6; 0xa8 is a hole
   localparam logic [7:0] VEC_LOW_BANK0 = 8'hb6;
   localparam logic [7:0] VEC_LOW_BANK1 = 8'ha6;
   localparam int BANK1_BASE = 7;
   localparam int IDX_T1_CH = 0;
   localparam int IDX_T1_OVF = 4;
   localparam int IDX_T1_PA_OVF = 5;
   localparam int IDX_T1_PA_EDGE = 6;
   localparam int IDX_T2_CH = 7;
   localparam int IDX_T2_OVF = 11;
   localparam int IDX_T2_PA_OVF = 12;
   localparam int IDX_T2_PA_EDGE = 13;
   localparam int IDX_PWM_RELOAD = 14;
   localparam int IDX_FAULT = 17;

   // ----------------------------------------------------------------
   // Reset vectors and priorities
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_VEC_POWER = 16'hfffe;
   localparam logic [15:0] RST_VEC_CLKMON = 16'hfffc;
   localparam logic [15:0] RST_VEC_WDOG = 16'hfffa;
   localparam logic [1:0] RST_PRIO_POWER = 2'h1;
   localparam logic [1:0] RST_PRIO_CLKMON = 2'h2;
   localparam logic [1:0] RST_PRIO_WDOG = 2'h3;

   // ----------------------------------------------------------------
   // Start-up values and memory size
   // ----------------------------------------------------------------
   localparam logic [7:0] ELEV_RESET = 8'h00;
   localparam logic [1:0] SYNC_RESET = 2'h3;
   localparam int RAM_DEPTH = 16;
   localparam int RAM_AW = 4;

   typedef struct packed {
      logic [1:0] rstSync;
      logic [7:0] elev;
      logic irqValid;
      logic [15:0] irqVector;
      logic [15:0] resetVector;
      logic [1:0] resetPriority;
      logic resetSeen;
      logic [7:0] ramRdData;
   } irv_state_t;

   localparam irv_state_t STATE_RESET = '{
      rstSync: SYNC_RESET,
      elev: ELEV_RESET,
      irqValid: 1'b0,
      irqVector: 16'h0000,
      resetVector: RST_VEC_POWER,
      resetPriority: RST_PRIO_POWER,
      resetSeen: 1'b0,
      ramRdData: 8'h00
   };

   // Low byte of the vector for a source index
   function automatic logic [7:0] srcVecLow(input logic [SRC_IDX_W-1:0] idx);
      logic [SRC_IDX_W-1:0] rel;
      rel = idx - SRC_IDX_W'(BANK1_BASE);
      if (idx < SRC_IDX_W'(BANK1_BASE))
         return VEC_LOW_BANK0 - {2'b00, idx, 1'b0};
      else
         return VEC_LOW_BANK1 - {2'b00, rel, 1'b0};
   endfunction : srcVecLow

   // True when a low byte belongs to a real source slot
   function automatic logic isValidVecLow(input logic [7:0] low);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (srcVecLow(SRC_IDX_W'(i)) == low)
            hit = 1'b1;
      end
      return hit;
   endfunction : isValidVecLow

endpackage : irv_pkg

// ==== logic/irv_arb_if.sv ====
// Carrier between the vector map top and its request arbiter.
// Assumes both ends sit on the same clock; the arbiter answers combinationally.
`timescale 1ns/1ps
interface irv_arb_if;
   logic [irv_pkg::NUM_SRC-1:0] req;
   logic [7:0] elev;
   logic valid;
   logic [7:0] vecLow;

   modport arb (input req, input elev, output valid, output vecLow);
   modport host (output req, output elev, input valid, input vecLow);
endinterface : irv_arb_if

// ==== logic/irv_arbiter.sv ====
// Combinational request arbiter: picks one vector among gated requests.
// Assumes requests are already masked; the caller registers the result.
`timescale 1ns/1ps
module irv_arbiter (
   irv_arb_if.arb arb
);

   // ----------------------------------------------------------------
   // Selection
   // ----------------------------------------------------------------
   always_comb
   begin
      arb.valid = |arb.req;
      arb.vecLow = 8'h00;
      // Scan downward so the lowest index, the highest address, is left standing
      for (int i = irv_pkg::NUM_SRC - 1; i >= 0; i--)
      begin
         if (arb.req[i])
            arb.vecLow = irv_pkg::srcVecLow(irv_pkg::SRC_IDX_W'(i)); // [RULE_13]
      end
      // A pending source whose slot matches the elevation code overrides the order
      for (int i = 0; i < irv_pkg::NUM_SRC; i++)
      begin
         if (arb.req[i] && irv_pkg::srcVecLow(irv_pkg::SRC_IDX_W'(i)) == arb.elev)
            arb.vecLow = arb.elev; // [RULE_11]
      end
   end

endmodule : irv_arbiter

// ==== tb/irv_src_model.sv ====
// Peripheral request sources seen by the vector map: timers and motor PWM.
// Assumes the bench drives req and en as one source-indexed pair, same clock.
`timescale 1ns/1ps
module irv_src_model (
   input wire logic [20:0] req,
   input wire logic [20:0] en,
   output logic [3:0] tim1ChReq,
   output logic [3:0] tim1ChannelIrqEn,
   output logic tim1OvfReq,
   output logic tim1OverflowIrqEn,
   output logic tim1PaOvfReq,
   output logic tim1PulseAccumOverflowIrqEn,
   output logic tim1PaEdgeReq,
   output logic tim1PulseAccumEdgeIrqEn,
   output logic [3:0] tim2ChReq,
   output logic [3:0] tim2ChannelIrqEn,
   output logic tim2OvfReq,
   output logic tim2OverflowIrqEn,
   output logic tim2PaOvfReq,
   output logic tim2PulseAccumOverflowIrqEn,
   output logic tim2PaEdgeReq,
   output logic tim2PulseAccumEdgeIrqEn,
   output logic [2:0] pwmReloadReq,
   output logic [2:0] genReloadIrqEn,
   output logic [3:0] faultReq,
   output logic [3:0] faultIrqEn
);
   // ----------------------------------------------------------------
   // Source index 0 is timer 1 channel 4, index 20 is fault 3
   // ----------------------------------------------------------------
   // Requests are plain levels held while the source stays pending
   assign {faultReq, pwmReloadReq, tim2PaEdgeReq, tim2PaOvfReq, tim2OvfReq, tim2ChReq,
      tim1PaEdgeReq, tim1PaOvfReq, tim1OvfReq, tim1ChReq} = req;
   assign {faultIrqEn, genReloadIrqEn, tim2PulseAccumEdgeIrqEn, tim2PulseAccumOverflowIrqEn,
      tim2OverflowIrqEn, tim2ChannelIrqEn, tim1PulseAccumEdgeIrqEn,
      tim1PulseAccumOverflowIrqEn, tim1OverflowIrqEn, tim1ChannelIrqEn} = en;
endmodule : irv_src_model

// ==== tb/irv_vector_map_test.sv ====
// Self-checking bench for the vector map, with a source-indexed reference model.
// Assumes irv_src_model unpacks the request and enable vectors onto the ports.
`timescale 1ns/1ps
module irv_vector_map_test;
   logic clk_sys = 1'b0;
   logic srst, iMask, elevWrEn, porReq, extResetPinN, lowVoltReq, clkMonReq, watchdogReq;
   logic ramWrEn, irqValid, resetSeen;
   logic [7:0] elevWrData, ramWrData, elevation, ramRdData, elevM;
   logic [3:0] ramAddr;
   logic [20:0] req, en;
   logic [15:0] irqVector, resetVector;
   logic [1:0] resetPriority;
   logic [3:0] tim1ChReq, tim1ChannelIrqEn, tim2ChReq, tim2ChannelIrqEn, faultReq, faultIrqEn;
   logic [2:0] pwmReloadReq, genReloadIrqEn;
   logic tim1OvfReq, tim1OverflowIrqEn, tim1PaOvfReq, tim1PulseAccumOverflowIrqEn;
   logic tim1PaEdgeReq, tim1PulseAccumEdgeIrqEn, tim2OvfReq, tim2OverflowIrqEn;
   logic tim2PaOvfReq, tim2PulseAccumOverflowIrqEn, tim2PaEdgeReq, tim2PulseAccumEdgeIrqEn;
   logic [7:0] mem [16];
   int n_fail = 0;
   int samples_checked = 0;

   always #2.5 clk_sys = ~clk_sys;

   irv_src_model src_u (.req, .en, .tim1ChReq, .tim1ChannelIrqEn, .tim1OvfReq,
      .tim1OverflowIrqEn, .tim1PaOvfReq, .tim1PulseAccumOverflowIrqEn, .tim1PaEdgeReq,
      .tim1PulseAccumEdgeIrqEn, .tim2ChReq, .tim2ChannelIrqEn, .tim2OvfReq,
      .tim2OverflowIrqEn, .tim2PaOvfReq, .tim2PulseAccumOverflowIrqEn, .tim2PaEdgeReq,
      .tim2PulseAccumEdgeIrqEn, .pwmReloadReq, .genReloadIrqEn, .faultReq, .faultIrqEn);

   irv_vector_map dut_u (.clk_sys, .srst, .iMask, .tim1ChReq, .tim1ChannelIrqEn, .tim1OvfReq,
      .tim1OverflowIrqEn, .tim1PaOvfReq, .tim1PulseAccumOverflowIrqEn, .tim1PaEdgeReq,
      .tim1PulseAccumEdgeIrqEn, .tim2ChReq, .tim2ChannelIrqEn, .tim2OvfReq,
      .tim2OverflowIrqEn, .tim2PaOvfReq, .tim2PulseAccumOverflowIrqEn, .tim2PaEdgeReq,
      .tim2PulseAccumEdgeIrqEn, .pwmReloadReq, .genReloadIrqEn, .faultReq, .faultIrqEn,
      .elevWrEn, .elevWrData, .porReq, .extResetPinN, .lowVoltReq, .clkMonReq, .watchdogReq,
      .ramWrEn, .ramAddr, .ramWrData, .irqValid, .irqVector, .elevation, .resetVector,
      .resetPriority, .resetSeen, .ramRdData);

   // ----------------------------------------------------------------
   // Reference model and checking
   // ----------------------------------------------------------------
   function automatic logic [7:0] lowOf(input int i);
      return (i < 7) ? 8'(8'hb6 - 2 * i) : 8'(8'ha6 - 2 * (i - 7));
   endfunction : lowOf

   function automatic logic [16:0] expIrq(input logic [20:0] r, input logic [20:0] e,
      input logic m, input logic [7:0] el);
      logic [20:0] g;
      int win;
      g = m ? 21'h0 : (r & e);
      win = -1;
      for (int i = 20; i >= 0; i--)
         if (g[i])
            win = i;
      // Elevation 0x00 matches no slot, so a cleared register never overrides
      for (int i = 0; i < 21; i++)
         if (g[i] && lowOf(i) == el)
            win = i;
      if (win < 0)
         return 17'h0;
      return {1'b1, 8'hff, lowOf(win)};
   endfunction : expIrq

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   // Called at a falling edge; result is due one rising edge later
   task automatic apply(input logic [20:0] r, input logic [20:0] e, input logic m);
      logic [16:0] x;
      x = expIrq(r, e, m, elevM);
      req = r;
      en = e;
      iMask = m;
      @(negedge clk_sys);
      chk(16'(irqValid), 16'(x[16]), "irq valid");
      chk(irqVector, x[15:0], "irq vector");
   endtask : apply

   task automatic setElev(input logic [7:0] v);
      elevWrEn = 1'b1;
      elevWrData = v;
      @(negedge clk_sys);
      elevWrEn = 1'b0;
      elevM = v;
      chk(16'(elevation), 16'(v), "elevation");
   endtask : setElev

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      #100000;
      n_fail++;
      end_sim();
   end

   initial
   begin
      {iMask, elevWrEn, porReq, lowVoltReq, clkMonReq, watchdogReq, ramWrEn} = '0;
      {req, en, elevWrData, ramWrData, ramAddr, elevM} = '0;
      extResetPinN = 1'b1;
      srst = 1'b1;
      void'($urandom(83032));
      repeat (20) @(negedge clk_sys);
      srst = 1'b0;
      chk(16'(elevation), 16'h0000, "elevation reset");
      chk(resetVector, 16'hfffe, "reset vector");
      chk({resetSeen, irqValid, resetPriority}, 16'h0001, "reset flags");
      $display("reset values done");
      for (int s = 0; s < 21; s++)
      begin
         apply(21'h1 << s, 21'h1 << s, 1'b0);
         apply(21'h1 << s, ~(21'h1 << s), 1'b0);
         apply(21'h1 << s, 21'h1 << s, 1'b1);
      end
      $display("single sources done");
      for (int s = 0; s < 21; s++)
      begin
         setElev(lowOf(s));
         apply((21'h1 << s) | 21'($urandom), 21'h1fffff, 1'b0);
      end
      $display("elevation done");
      for (int i = 0; i < 300; i++)
      begin
         if (i % 16 == 0)
            setElev((i % 32 == 0) ? 8'($urandom) : lowOf($urandom % 21));
         apply(21'($urandom), 21'($urandom), ($urandom % 4) == 0);
      end
      $display("random traffic done");
      for (int v = 1; v < 16; v++)
      begin
         setElev(lowOf(v));
         {req, en, iMask} = {21'h1fffff, 21'h1fffff, 1'b0};
         {porReq, lowVoltReq, clkMonReq, watchdogReq} = 4'(v);
         @(negedge clk_sys);
         chk(resetVector, v >= 4 ? 16'hfffe : v >= 2 ? 16'hfffc : 16'hfffa, "cause");
         chk(16'(resetPriority), v >= 4 ? 16'h1 : v >= 2 ? 16'h2 : 16'h3, "prio");
         chk({elevation, 6'h0, resetSeen, irqValid}, 16'h0002, "local reset");
         {porReq, lowVoltReq, clkMonReq, watchdogReq} = 4'h0;
         elevM = 8'h00;
      end
      srst = 1'b1;
      @(negedge clk_sys);
      srst = 1'b0;
      chk({resetVector[7:0], 6'h0, resetSeen, resetPriority[0]}, 16'hfe01, "srst");
      setElev(8'h9a);
      extResetPinN = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk({elevation, 7'h0, resetSeen}, 16'h9a00, "pin early");
      @(negedge clk_sys);
      chk({elevation, 7'h0, resetSeen}, 16'h0001, "pin reset");
      chk(resetVector, 16'hfffe, "pin vector");
      extResetPinN = 1'b1;
      elevM = 8'h00;
      repeat (3) @(negedge clk_sys);
      $display("resets done");
      ramWrEn = 1'b1;
      for (int a = 0; a < 16; a++)
      begin
         ramAddr = 4'(a);
         ramWrData = 8'($urandom);
         mem[a] = ramWrData;
         @(negedge clk_sys);
      end
      // Writes under either reset kind must be dropped, not just the array kept
      {ramAddr, ramWrData, porReq} = {4'h5, ~mem[5], 1'b1};
      @(negedge clk_sys);
      {ramAddr, ramWrData, porReq, srst} = {4'h6, ~mem[6], 1'b0, 1'b1};
      @(negedge clk_sys);
      {ramWrEn, srst} = 2'b00;
      for (int a = 0; a < 16; a++)
      begin
         ramAddr = 4'(a);
         @(negedge clk_sys);
         chk(16'(ramRdData), 16'(mem[a]), "ram");
      end
      $display("ram retention done");
      end_sim();
   end
endmodule : irv_vector_map_test
